// ---- power_loop_feedback_control.sv ----
/*
 * Closed loop power regulation core: feedback law, power and current
 * limit loops, lesser-demand selection toward the firing stage.
 * Assumes meas_done pulses once per finished RMS period with v_rms and
 * i_rms valid in that cycle, and at least 70 cycles between pulses.
 */
`timescale 1ns/10ps

// Function
// [RULE1] power loop steers its demand so feedback follows the set point
// [RULE2] current loop counts only while current limiting is enabled
// [RULE3] demand is the lesser loop output while current limit is active
// [RULE4] current loop winning selects phase angle firing and raises alarm
// [RULE5] current error is limit set point minus measured current
// [RULE6] power error is set point minus selected feedback
// [RULE7] each loop is PI with its own proportional and integral gain
// [RULE8] voltage feedback is Vrms over nominal volts, in percent
// [RULE9] voltage squared feedback is that ratio squared, in percent
// [RULE10] power feedback is V times I over nominal product, in percent
// [RULE11] current squared feedback is current ratio squared, in percent
// [RULE12] current feedback is Irms over nominal current, in percent
// [RULE13] no feedback: demand equals set point, no measured correction
// [RULE14] linear no feedback: ideal sine on-time for set point power
// [RULE15] set point means percent of the quantity the feedback implies
// [RULE16] set point arrives as a parameter or as an analog input
// [RULE17] set point is multiplied by output scaling before the loops
// [RULE18] force voltage feedback input overrides the feedback type
// [RULE19] unconnected enable input means the output is enabled
// [RULE20] update once per RMS period, integrators clamped to 0..full
module power_loop_feedback_control (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // measurement, once per rms period
    input wire logic meas_done,
    input wire logic [15:0] v_rms,
    input wire logic [15:0] i_rms,
    // nominal load ratings
    input wire logic [15:0] v_nom,
    input wire logic [15:0] i_nom,
    // set point sources and scaling, percent x100
    input wire logic [15:0] sp_param,
    input wire logic [15:0] sp_analog,
    input wire logic sp_from_analog,
    input wire logic [15:0] out_scale,
    // feedback selection
    input wire logic [2:0] fb_type,
    input wire logic force_vfb,
    // output enable
    input wire logic en_connected,
    input wire logic en_in,
    // power loop tuning
    input wire logic [15:0] pd_kp,
    input wire logic [15:0] pd_ki,
    // current limit loop
    input wire logic cl_enable,
    input wire logic [15:0] cl_setpoint,
    input wire logic [15:0] cl_kp,
    input wire logic [15:0] cl_ki,
    // toward firing stage and status
    output logic [15:0] demand_q,
    output logic phase_fire_q,
    output logic cl_alarm_q,
    output logic [15:0] feedback_q,
    output logic update_q
);
    power_loop_pkg::seq_state_type state_q, state_d;
    logic [15:0] i_cap_q, i_cap_d;
    logic [15:0] rv_q, rv_d;
    logic [15:0] ri_q, ri_d;
    logic [15:0] sp_q, sp_d;
    logic [15:0] fb_q, fb_d;
    logic [15:0] demand_d, feedback_d;
    logic phase_fire_d, cl_alarm_d, update_d;
    logic div_start, div_done;
    logic [15:0] div_num, div_den, div_quo;
    logic [2:0] fb_sel;
    logic closed_loop, enabled, cl_wins;
    logic [15:0] sp_src, sp_eff, fb_calc, pd_dem;
    logic [31:0] sp_prod;

    pi_if pd_bus ();
    pi_if cl_bus ();

    // =====================================================================
    // helpers
    function automatic logic [15:0] sat16(input logic [31:0] v);
        sat16 = (|v[31:16]) ? power_loop_pkg::SAT_MAX : v[15:0];
    endfunction

    // product of two percentages, back to percent
    function automatic logic [15:0] pct_mul(input logic [15:0] a,
        input logic [15:0] b);
        logic [31:0] p;
        p = ({16'h0000, a} * {16'h0000, b})
            / {16'h0000, power_loop_pkg::FULL_SCALE};
        pct_mul = sat16(p);
    endfunction

    // piecewise linear inverse of the sine power curve
    function automatic logic [15:0] lin_on_time(input logic [15:0] sp);
        logic [31:0] p16, seg, frac, step, base;
        p16 = {16'h0000, sp} << 4;
        seg = p16 / {16'h0000, power_loop_pkg::FULL_SCALE};
        frac = p16 % {16'h0000, power_loop_pkg::FULL_SCALE};
        if (seg >= 32'(power_loop_pkg::LIN_SEGS)) begin
            lin_on_time = power_loop_pkg::LIN_TABLE[16];
        end else begin
            base = {16'h0000, power_loop_pkg::LIN_TABLE[seg[4:0]]};
            step = {16'h0000, power_loop_pkg::LIN_TABLE[seg[4:0] + 5'h01]}
                - base;
            lin_on_time = sat16(base + (step * frac)
                / {16'h0000, power_loop_pkg::FULL_SCALE});
        end
    endfunction

    // =====================================================================
    // operating conditions
    assign fb_sel = force_vfb ? 3'(power_loop_pkg::FB_VOLT) : fb_type; // RULE18
    assign closed_loop = (fb_sel != 3'(power_loop_pkg::FB_NONE))
        && (fb_sel != 3'(power_loop_pkg::FB_NONE_LIN));
    assign enabled = !en_connected || en_in; // RULE19
    assign sp_src = sp_from_analog ? sp_analog : sp_param; // RULE16
    assign sp_prod = ({16'h0000, sp_src} * {16'h0000, out_scale})
        / {16'h0000, power_loop_pkg::FULL_SCALE}; // RULE17
    // effective set point never asks beyond full scale
    assign sp_eff = (sp_prod > {16'h0000, power_loop_pkg::FULL_SCALE})
        ? power_loop_pkg::FULL_SCALE : sp_prod[15:0];

    // =====================================================================
    // one divider shared for both ratios, voltage first
    assign div_start = (state_q == power_loop_pkg::ST_IDLE && meas_done)
        || (state_q == power_loop_pkg::ST_DIV_V && div_done);
    assign div_num = (state_q == power_loop_pkg::ST_IDLE) ? v_rms : i_cap_q;
    assign div_den = (state_q == power_loop_pkg::ST_IDLE) ? v_nom : i_nom;

    ratio_div u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(div_start),
        .num(div_num),
        .den(div_den),
        .done(div_done),
        .quo(div_quo)
    );

    // =====================================================================
    // feedback law from the two ratios, set point read in the same units
    always_comb begin
        case (fb_sel)
            3'(power_loop_pkg::FB_VOLT): fb_calc = rv_q; // RULE8 RULE15
            3'(power_loop_pkg::FB_VOLT_SQ): fb_calc = pct_mul(rv_q, rv_q); // RULE9
            3'(power_loop_pkg::FB_POWER): fb_calc = pct_mul(rv_q, ri_q); // RULE10
            3'(power_loop_pkg::FB_CURR_SQ): fb_calc = pct_mul(ri_q, ri_q); // RULE11
            3'(power_loop_pkg::FB_CURR): fb_calc = ri_q; // RULE12
            default: fb_calc = 16'h0000;
        endcase
    end

    // =====================================================================
    // loops, stepped once per period; power loop frozen without feedback
    assign pd_bus.err = $signed({1'b0, sp_eff}) - $signed({1'b0, fb_calc}); // RULE6
    assign pd_bus.kp = pd_kp;
    assign pd_bus.ki = pd_ki;
    assign pd_bus.step = (state_q == power_loop_pkg::ST_CALC) && enabled
        && closed_loop; // RULE1 RULE20
    assign cl_bus.err = $signed({1'b0, cl_setpoint})
        - $signed({1'b0, i_cap_q}); // RULE5
    assign cl_bus.kp = cl_kp;
    assign cl_bus.ki = cl_ki;
    assign cl_bus.step = (state_q == power_loop_pkg::ST_CALC) && enabled
        && cl_enable; // RULE2

    pi_loop u_pd_loop (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bus(pd_bus)
    );

    pi_loop u_cl_loop (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bus(cl_bus)
    );

    // =====================================================================
    // demand selection
    always_comb begin
        if (closed_loop)
            pd_dem = pd_bus.outv; // RULE1
        else if (fb_sel == 3'(power_loop_pkg::FB_NONE_LIN))
            pd_dem = lin_on_time(sp_q); // RULE14
        else
            pd_dem = sp_q; // RULE13
    end
    assign cl_wins = cl_enable && (cl_bus.outv < pd_dem); // RULE2 RULE3

    // =====================================================================
    // sequencer: capture, two divisions, loop step, publish
    always_comb begin
        state_d = state_q;
        i_cap_d = i_cap_q;
        rv_d = rv_q;
        ri_d = ri_q;
        sp_d = sp_q;
        fb_d = fb_q;
        demand_d = demand_q;
        feedback_d = feedback_q;
        phase_fire_d = phase_fire_q;
        cl_alarm_d = cl_alarm_q;
        update_d = 1'b0;
        case (state_q)
            power_loop_pkg::ST_IDLE: begin
                if (meas_done) begin
                    i_cap_d = i_rms;
                    state_d = power_loop_pkg::ST_DIV_V;
                end
            end
            power_loop_pkg::ST_DIV_V: begin
                if (div_done) begin
                    rv_d = div_quo;
                    state_d = power_loop_pkg::ST_DIV_I;
                end
            end
            power_loop_pkg::ST_DIV_I: begin
                if (div_done) begin
                    ri_d = div_quo;
                    state_d = power_loop_pkg::ST_CALC;
                end
            end
            power_loop_pkg::ST_CALC: begin
                sp_d = sp_eff;
                fb_d = fb_calc;
                state_d = power_loop_pkg::ST_LOOP;
            end
            power_loop_pkg::ST_LOOP: begin
                // disabled output asks for nothing and holds the loops
                if (!enabled)
                    demand_d = 16'h0000;
                else if (cl_wins)
                    demand_d = cl_bus.outv; // RULE3
                else
                    demand_d = pd_dem;
                phase_fire_d = enabled && cl_wins; // RULE4
                cl_alarm_d = enabled && cl_wins; // RULE4
                feedback_d = fb_q;
                update_d = 1'b1;
                state_d = power_loop_pkg::ST_IDLE;
            end
            default: state_d = power_loop_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= power_loop_pkg::ST_IDLE;
            i_cap_q <= 16'h0000;
            rv_q <= 16'h0000;
            ri_q <= 16'h0000;
            sp_q <= 16'h0000;
            fb_q <= 16'h0000;
            demand_q <= 16'h0000;
            feedback_q <= 16'h0000;
            phase_fire_q <= 1'b0;
            cl_alarm_q <= 1'b0;
            update_q <= 1'b0;
        end else begin
            state_q <= state_d;
            i_cap_q <= i_cap_d;
            rv_q <= rv_d;
            ri_q <= ri_d;
            sp_q <= sp_d;
            fb_q <= fb_d;
            demand_q <= demand_d;
            feedback_q <= feedback_d;
            phase_fire_q <= phase_fire_d;
            cl_alarm_q <= cl_alarm_d;
            update_q <= update_d;
        end
    end

    // =====================================================================
    // checks
    sequence meas_taken_s;
        state_q == power_loop_pkg::ST_IDLE && meas_done;
    endsequence
    sequence published_s;
        ##69 update_q;
    endsequence

    period_update_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        meas_taken_s |-> published_s) // RULE20
        else $error("demand not published 69 cycles after measurement");
    cl_only_enabled_a: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        update_q && !$past(cl_enable) |-> !cl_alarm_q) // RULE2
        else $error("current alarm while limiting disabled");
    lesser_demand_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        update_q && $past(enabled) |-> demand_q <= $past(pd_dem)) // RULE3
        else $error("demand above power loop output");
    alarm_phase_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        update_q |-> cl_alarm_q == phase_fire_q && (cl_alarm_q
        == ($past(enabled) && demand_q < $past(pd_dem)))) // RULE4
        else $error("alarm and phase firing disagree with selection");
    cl_error_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cl_bus.step && i_cap_q > cl_setpoint |-> cl_bus.err < 0) // RULE5
        else $error("current error sign wrong");
    pd_error_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pd_bus.step |-> (pd_bus.err > 0) == (sp_eff > fb_calc)) // RULE6
        else $error("power error sign wrong");
    volt_fb_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == power_loop_pkg::ST_CALC
        && fb_sel == 3'(power_loop_pkg::FB_VOLT) |=> fb_q == $past(rv_q)) // RULE8
        else $error("voltage feedback not the voltage ratio");
    open_loop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == power_loop_pkg::ST_LOOP && enabled && !cl_enable
        && fb_sel == 3'(power_loop_pkg::FB_NONE) |=> demand_q == $past(sp_q)) // RULE13
        else $error("open loop demand differs from set point");
    scale_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        out_scale == power_loop_pkg::FULL_SCALE
        && sp_src <= power_loop_pkg::FULL_SCALE |-> sp_eff == sp_src) // RULE17
        else $error("full scaling changed the set point");
    force_volt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        force_vfb |-> fb_sel == 3'(power_loop_pkg::FB_VOLT)) // RULE18
        else $error("force voltage feedback ignored");
    default_enable_a: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        update_q && !$past(en_connected) && $past(pd_dem) > 16'h0000
        && !$past(cl_enable) |-> demand_q != 16'h0000) // RULE19
        else $error("unconnected enable blocked the output");
endmodule

// ---- power_loop_pkg.sv ----
/*
 * Shared constants and types for the power loop feedback core.
 * Assumes percentages are unsigned fixed point, 10000 counts = 100.00 %.
 */
package power_loop_pkg;

    // =====================================================================
    // fixed point scale
    localparam logic [15:0] FULL_SCALE = 16'h2710;
    localparam logic [15:0] SAT_MAX = 16'hFFFF;
    localparam int GAIN_FRAC = 8;
    localparam logic [15:0] SCALE_RESET = 16'h2710;

    // =====================================================================
    // divider sequencing
    localparam logic [5:0] DIV_STEPS = 6'h20;
    localparam int DIV_LATENCY = 33;
    localparam int UPDATE_LATENCY = 69;

    // =====================================================================
    // feedback laws
    typedef enum logic [2:0] {
        FB_VOLT = 3'h0,
        FB_VOLT_SQ = 3'h1,
        FB_POWER = 3'h2,
        FB_CURR_SQ = 3'h3,
        FB_CURR = 3'h4,
        FB_NONE = 3'h5,
        FB_NONE_LIN = 3'h6
    } fb_mode_type;

    // =====================================================================
    // sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_DIV_V = 5'h02,
        ST_DIV_I = 5'h04,
        ST_CALC = 5'h08,
        ST_LOOP = 5'h10
    } seq_state_type;

    // =====================================================================
    // ideal sine: conduction fraction for power k/16, phase angle firing
    localparam int LIN_SEGS = 16;
    localparam logic [15:0] LIN_TABLE [0:16] = '{
        16'h0000, 16'h0875, 16'h0AEC, 16'h0CC4, 16'h0E55, 16'h0FC0,
        16'h110B, 16'h124D, 16'h1388, 16'h14C3, 16'h1605, 16'h1750,
        16'h18BB, 16'h1A4C, 16'h1C24, 16'h1E9B, 16'h2710
    };

endpackage

// ---- pi_if.sv ----
/*
 * Connection between the sequencer and one proportional-integral loop.
 * Assumes one driver per side: controller drives error, gains and step.
 */
`timescale 1ns/10ps
interface pi_if;
    logic signed [16:0] err;
    logic [15:0] kp;
    logic [15:0] ki;
    logic step;
    logic [15:0] outv;

    modport loop (input err, input kp, input ki, input step, output outv);
    modport ctrl (output err, output kp, output ki, output step,
        input outv);
endinterface

// ---- ratio_div.sv ----
/*
 * Sequential divider: quotient = num * full scale / den, saturated.
 * Assumes start is only raised while idle; answer 33 cycles later.
 */
`timescale 1ns/10ps
module ratio_div (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // request
    input wire logic start,
    input wire logic [15:0] num,
    input wire logic [15:0] den,
    // answer
    output logic done,
    output logic [15:0] quo
);
    logic [31:0] dvd_q, dvd_d;
    logic [16:0] rem_q, rem_d;
    logic [15:0] den_q, den_d;
    logic [5:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic [16:0] trial;

    // =====================================================================
    // restoring division, one quotient bit per cycle
    always_comb begin
        dvd_d = dvd_q;
        rem_d = rem_q;
        den_d = den_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        trial = {rem_q[15:0], dvd_q[31]};
        if (start && !busy_q) begin
            dvd_d = {16'h0000, num} * {16'h0000, power_loop_pkg::FULL_SCALE};
            rem_d = 17'h00000;
            den_d = den;
            cnt_d = power_loop_pkg::DIV_STEPS;
            busy_d = 1'b1;
        end else if (busy_q) begin
            // zero divisor gives all ones, which saturates below
            if (trial >= {1'b0, den_q}) begin
                rem_d = trial - {1'b0, den_q};
                dvd_d = {dvd_q[30:0], 1'b1};
            end else begin
                rem_d = trial;
                dvd_d = {dvd_q[30:0], 1'b0};
            end
            cnt_d = cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dvd_q <= 32'h00000000;
            rem_q <= 17'h00000;
            den_q <= 16'h0000;
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            dvd_q <= dvd_d;
            rem_q <= rem_d;
            den_q <= den_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;
    // ratios above 655 % saturate
    assign quo = (|dvd_q[31:16]) ? power_loop_pkg::SAT_MAX : dvd_q[15:0];

    div_latency_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        start && !busy_q |-> ##33 done_q) // RULE8
        else $error("divider answer not 33 cycles after start");
endmodule

// ---- pi_loop.sv ----
/*
 * One proportional-integral loop with anti-windup clamp.
 * Assumes gains are unsigned with 8 fraction bits; steps once per period.
 */
`timescale 1ns/10ps
module pi_loop (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // loop connection
    pi_if.loop bus
);
    logic [15:0] integ_q, integ_d;
    logic [15:0] out_q, out_d;
    logic signed [33:0] p_term, i_term, isum, osum;

    function automatic logic [15:0] clamp_full(input logic signed [33:0] v);
        if (v < 0)
            clamp_full = 16'h0000;
        else if (v > $signed({18'h00000, power_loop_pkg::FULL_SCALE}))
            clamp_full = power_loop_pkg::FULL_SCALE;
        else
            clamp_full = v[15:0];
    endfunction

    // =====================================================================
    // integrator clamped inside 0..full so it cannot wind up
    always_comb begin
        p_term = ($signed({1'b0, bus.kp}) * bus.err)
            >>> power_loop_pkg::GAIN_FRAC; // RULE7
        i_term = ($signed({1'b0, bus.ki}) * bus.err)
            >>> power_loop_pkg::GAIN_FRAC; // RULE7
        isum = $signed({18'h00000, integ_q}) + i_term;
        integ_d = integ_q;
        out_d = out_q;
        osum = 34'sh000000000;
        if (bus.step) begin
            integ_d = clamp_full(isum); // RULE20
            osum = p_term + $signed({18'h00000, integ_d});
            out_d = clamp_full(osum); // RULE20
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            integ_q <= 16'h0000;
            out_q <= 16'h0000;
        end else begin
            integ_q <= integ_d;
            out_q <= out_d;
        end
    end

    assign bus.outv = out_q;

    pi_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        integ_q <= power_loop_pkg::FULL_SCALE
        && out_q <= power_loop_pkg::FULL_SCALE) // RULE20
        else $error("loop state outside zero to full range");

    pi_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !bus.step |=> $stable(out_q) && $stable(integ_q)) // RULE20
        else $error("loop moved without a step");
endmodule

// ---- fire_model.sv ----
/*
 * Firing stage stand-in: keeps the demand that the switch would fire.
 * Assumes update pulses for one cycle while demand and flags are settled.
 */
`timescale 1ns/10ps
module fire_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // from the loop core
    input wire logic [15:0] demand,
    input wire logic phase_fire,
    input wire logic update,
    // what the switch is firing now
    output logic [15:0] fire_q,
    output logic angle_q
);
    // take demand only on the pulse; a real stage ignores it between
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fire_q <= 16'h0000;
            angle_q <= 1'b0;
        end else if (update) begin
            fire_q <= demand;
            angle_q <= phase_fire;
        end
    end
endmodule

// ---- tb_top.sv ----
/*
 * Self-checking bench for the power loop core, table rows then edge cases.
 * Assumes each measurement is answered 69 cycles after it is taken.
 */
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic [2:0] fb;
        logic fv;
        logic [15:0] sp, sc, cs, efb, edm;
        logic ef;
    } row_type;
    // ==================================================================
    // stimulus and observed signals
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic meas_done = 1'b0, sp_from_analog = 1'b0, force_vfb = 1'b0;
    logic en_connected = 1'b0, en_in = 1'b0, cl_enable = 1'b0;
    logic [15:0] v_rms = 16'h01F4, i_rms = 16'h0050;
    logic [15:0] sp_param = 16'h2710, sp_analog = 16'h0000;
    logic [15:0] out_scale = 16'h2710, cl_setpoint = 16'h0000;
    logic [15:0] pd_kp = 16'h0100, pd_ki = 16'h0000;
    logic [15:0] cl_kp = 16'h0100, cl_ki = 16'h0000;
    logic [2:0] fb_type = 3'h0;
    logic [15:0] demand_q, feedback_q, fire_q;
    logic phase_fire_q, cl_alarm_q, update_q, angle_q;
    int err_count = 0, tests_run = 0, cyc = 0, n;
    row_type rows [0:10];

    always #50 clk_sys = ~clk_sys;

    // hang guard: the whole run needs about 1220 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count = err_count + 1;
            end_of_test();
        end
    end

    // nominal ratings fixed at 1000 volt and 100 ampere units
    power_loop_feedback_control u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .meas_done(meas_done), .v_rms(v_rms), .i_rms(i_rms),
        .v_nom(16'h03E8), .i_nom(16'h0064), .sp_param(sp_param),
        .sp_analog(sp_analog), .sp_from_analog(sp_from_analog),
        .out_scale(out_scale), .fb_type(fb_type), .force_vfb(force_vfb),
        .en_connected(en_connected), .en_in(en_in), .pd_kp(pd_kp),
        .pd_ki(pd_ki), .cl_enable(cl_enable), .cl_setpoint(cl_setpoint),
        .cl_kp(cl_kp), .cl_ki(cl_ki), .demand_q(demand_q),
        .phase_fire_q(phase_fire_q), .cl_alarm_q(cl_alarm_q),
        .feedback_q(feedback_q), .update_q(update_q));

    fire_model u_fire (.clk_sys(clk_sys), .rst_n(rst_n),
        .demand(demand_q), .phase_fire(phase_fire_q), .update(update_q),
        .fire_q(fire_q), .angle_q(angle_q));

    // ==================================================================
    // shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    // one pulse, then count edges until the answer; bounded wait
    task automatic meas;
        @(posedge clk_sys);
        meas_done <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            meas_done <= 1'b0;
            n++;
            #1;
        end while (update_q !== 1'b1 && n < 90);
    endtask

    task automatic step_chk(input logic [15:0] exp);
        meas();
        chk(demand_q, exp);
    endtask

    task automatic end_of_test;
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==================================================================
    // main sequence; v 50 %, i 80 %, kp 1.0 and ki 0 keep demand = error
    initial begin
        rows = '{
            '{3'h0, 1'b0, 16'h2710, 16'h2710, 16'h0, 16'h1388, 16'h1388, 1'b0},
            '{3'h1, 1'b0, 16'h2710, 16'h2710, 16'h0, 16'h09C4, 16'h1D4C, 1'b0},
            '{3'h2, 1'b0, 16'h2710, 16'h2710, 16'h0, 16'h0FA0, 16'h1770, 1'b0},
            '{3'h3, 1'b0, 16'h2710, 16'h2710, 16'h0, 16'h1900, 16'h0E10, 1'b0},
            '{3'h4, 1'b0, 16'h2710, 16'h2710, 16'h0, 16'h1F40, 16'h07D0, 1'b0},
            '{3'h4, 1'b1, 16'h2710, 16'h2710, 16'h0, 16'h1388, 16'h1388, 1'b0},
            '{3'h4, 1'b0, 16'h2710, 16'h2710, 16'h64, 16'h1F40, 16'h14, 1'b1},
            '{3'h4, 1'b0, 16'h2710, 16'h2710, 16'h32, 16'h1F40, 16'h0, 1'b1},
            '{3'h4, 1'b0, 16'h2710, 16'h2710, 16'h2328, 16'h1F40, 16'h7D0, 1'b0},
            '{3'h5, 1'b0, 16'h1388, 16'h1F40, 16'h0, 16'h0, 16'h0FA0, 1'b0},
            '{3'h6, 1'b0, 16'h09C4, 16'h2710, 16'h0, 16'h0, 16'h0E55, 1'b0}};
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        chk(demand_q, 16'h0000);
        foreach (rows[k]) begin
            @(posedge clk_sys);
            fb_type <= rows[k].fb;
            force_vfb <= rows[k].fv;
            sp_param <= rows[k].sp;
            out_scale <= rows[k].sc;
            cl_setpoint <= rows[k].cs;
            cl_enable <= (rows[k].cs != 16'h0000);
            meas();
            chk(16'(n), 16'h0045);
            if (rows[k].fb < 3'h5)
                chk(feedback_q, rows[k].efb);
            chk(demand_q, rows[k].edm);
            chk({14'h0, phase_fire_q, cl_alarm_q}, {14'h0, {2{rows[k].ef}}});
            @(posedge clk_sys);
            #1;
            chk(fire_q, rows[k].edm);
            chk({15'h0, angle_q}, {15'h0, rows[k].ef});
        end
        // analog source, then the wired enable both ways
        @(posedge clk_sys);
        sp_from_analog <= 1'b1;
        sp_analog <= 16'h1388;
        fb_type <= 3'h5;
        step_chk(16'h1388);
        @(posedge clk_sys);
        en_connected <= 1'b1;
        step_chk(16'h0000);
        @(posedge clk_sys);
        en_in <= 1'b1;
        step_chk(16'h1388);
        // integral only: whole error each period, then clamped at full
        @(posedge clk_sys);
        sp_from_analog <= 1'b0;
        sp_param <= 16'h2710;
        fb_type <= 3'h0;
        pd_kp <= 16'h0000;
        pd_ki <= 16'h0100;
        step_chk(16'h1388);
        step_chk(16'h2710);
        step_chk(16'h2710);
        end_of_test();
    end
endmodule
